/* File: design/dual_timer_split_mode_core.sv */
// Two counter/timers with control, mode and prescale registers and external interrupt flags
`timescale 1ns/1ps
`include "timer_core_cfg.svh"
module dual_timer_split_mode_core (
  input wire logic ref_clk_i, // 25 MHz system clock
  input wire logic rstn_i, // Asynchronous reset, active low
  input wire logic sfr_wr_i, // Register write strobe
  input wire logic sfr_rd_i, // Register read strobe
  input wire logic [7:0] sfr_addr_i, // Register address
  input wire logic [7:0] sfr_wdata_i, // Write data
  output logic [7:0] sfr_rdata_o, // Registered read data
  output logic sfr_hit_o, // Address belongs to this block
  input wire logic ack_t0_i, // Vector to first timer interrupt
  input wire logic ack_t1_i, // Vector to second timer interrupt
  input wire logic ack_x0_i, // Vector to line 0 interrupt
  input wire logic ack_x1_i, // Vector to line 1 interrupt
  input wire logic ext_irq_pin_line0_i, // Interrupt pin line 0, active low
  input wire logic ext_irq_pin_line1_i, // Interrupt pin line 1, active low
  input wire logic first_count_input_pin_i, // First timer count pin
  input wire logic second_count_input_pin_i, // Second timer count pin
  input wire logic ext_clk_i, // External clock for prescaler
  output logic first_timer_irq_o, // First timer overflow flag level
  output logic second_timer_irq_o, // Second timer overflow flag level
  output logic ext_irq_line0_o, // Line 0 flag level
  output logic ext_irq_line1_o, // Line 1 flag level
  output logic second_timer_ovf_strobe_o // Second timer overflow strobe
);
  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] control_reg;
  logic [7:0] mode_reg;
  logic [7:0] prescale_reg;
  logic [7:0] t0_low_reg;
  logic [7:0] t0_high_reg;
  logic [7:0] t1_low_reg;
  logic [7:0] t1_high_reg;
  logic [7:0] rdata_reg;
  logic strobe_reg;

  // Decoded request and mode fields
  timer_core_pkg::sfr_req_type req;
  timer_core_pkg::timer_cfg_type cfg0;
  timer_core_pkg::timer_cfg_type cfg1;

  // Synchronised pin levels and falling edges
  logic x0_level;
  logic x0_fall;
  logic x1_level;
  logic x1_fall;
  logic c0_level;
  logic c0_fall;
  logic c1_level;
  logic c1_fall;
  // Prescaler input and tick
  logic xc_fall;
  logic pre_tick;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  pin_sync sync_x0 (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .pin_i(ext_irq_pin_line0_i),
    .level_o(x0_level), .fall_o(x0_fall));
  pin_sync sync_x1 (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .pin_i(ext_irq_pin_line1_i),
    .level_o(x1_level), .fall_o(x1_fall));
  pin_sync sync_c0 (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .pin_i(first_count_input_pin_i),
    .level_o(c0_level), .fall_o(c0_fall));
  pin_sync sync_c1 (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .pin_i(second_count_input_pin_i),
    .level_o(c1_level), .fall_o(c1_fall));
  pin_sync sync_xc (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .pin_i(ext_clk_i),
    .level_o(), .fall_o(xc_fall));

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler
  prescaler presc (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .scale_i(prescale_reg[1:0]),
    .ext_fall_i(xc_fall), .tick_o(pre_tick));

  ////////////////////////////////////////////////////////////////////////////
  // Request and field decode
  // Bus request bundle
  assign req = '{wr: sfr_wr_i, addr: sfr_addr_i, wdata: sfr_wdata_i};
  // Gate, counter select and mode per timer
  assign cfg0 = '{pin_gating: mode_reg[`MOD_T0_GATE], counter_select: mode_reg[`MOD_T0_CNT],
    mode: timer_core_pkg::timer_mode_type'(mode_reg[`MOD_T0_MODE_HI:`MOD_T0_MODE_LO])};
  assign cfg1 = '{pin_gating: mode_reg[`MOD_T1_GATE], counter_select: mode_reg[`MOD_T1_CNT],
    mode: timer_core_pkg::timer_mode_type'(mode_reg[`MOD_T1_MODE_HI:`MOD_T1_MODE_LO])};

  // Write strobes, one per register
  wire wr_ctl = req.wr && (req.addr == `ADDR_CONTROL);
  wire wr_mod = req.wr && (req.addr == `ADDR_MODE);
  wire wr_t0l = req.wr && (req.addr == `ADDR_T0_LOW);
  wire wr_t1l = req.wr && (req.addr == `ADDR_T1_LOW);
  wire wr_t0h = req.wr && (req.addr == `ADDR_T0_HIGH);
  wire wr_t1h = req.wr && (req.addr == `ADDR_T1_HIGH);
  wire wr_ck = req.wr && (req.addr == `ADDR_PRESCALE);

  // First timer split into two byte counters
  wire split0 = (cfg0.mode == timer_core_pkg::MODE_SPLIT);

  ////////////////////////////////////////////////////////////////////////////
  // Run gating and count sources
  wire run0 = control_reg[`CTL_T0_RUN];
  wire run1 = control_reg[`CTL_T1_RUN];
  wire en0 = run0 && (!cfg0.pin_gating || x0_level);
  wire en1_norm = run1 && (!cfg1.pin_gating || x1_level);
  wire en1 = split0 ? (cfg1.mode != timer_core_pkg::MODE_SPLIT) : en1_norm;

  // Timer clock: system clock every cycle or prescaled tick
  wire clk0_int = prescale_reg[`CK_T0_SEL] ? 1'b1 : pre_tick;
  wire clk1_int = prescale_reg[`CK_T1_SEL] ? 1'b1 : pre_tick;

  // Increment request per counter
  wire inc0 = en0 && (cfg0.counter_select ? c0_fall : clk0_int);
  wire inc1_norm = cfg1.counter_select ? c1_fall : clk1_int;
  wire inc1 = en1 && (split0 ? clk1_int : inc1_norm);
  wire inc0h = split0 && run1 && clk0_int;

  ////////////////////////////////////////////////////////////////////////////
  // Counter next values for first timer
  logic [7:0] t0_low_next;
  logic [7:0] t0_high_next;
  logic ovf0;
  logic ovf0h;
  always_comb
  begin
    t0_low_next = t0_low_reg;
    t0_high_next = t0_high_reg;
    ovf0 = 1'b0;
    ovf0h = 1'b0;
    if (inc0)
    begin
      case (cfg0.mode)
        timer_core_pkg::MODE_13BIT:
        begin
          t0_low_next = {t0_low_reg[7:5], t0_low_reg[4:0] + 5'h01};
          if (t0_low_reg[4:0] == `LOW5_ONES)
          begin
            t0_high_next = t0_high_reg + 8'h01;
            ovf0 = (t0_high_reg == `BYTE_ONES);
          end
        end
        timer_core_pkg::MODE_16BIT:
        begin
          t0_low_next = t0_low_reg + 8'h01;
          if (t0_low_reg == `BYTE_ONES)
          begin
            t0_high_next = t0_high_reg + 8'h01;
            ovf0 = (t0_high_reg == `BYTE_ONES);
          end
        end
        timer_core_pkg::MODE_RELOAD:
        begin
          ovf0 = (t0_low_reg == `BYTE_ONES);
          t0_low_next = ovf0 ? t0_high_reg : t0_low_reg + 8'h01;
        end
        timer_core_pkg::MODE_SPLIT:
        begin
          t0_low_next = t0_low_reg + 8'h01;
          ovf0 = (t0_low_reg == `BYTE_ONES);
        end
        default:
        begin
          t0_low_next = t0_low_reg;
        end
      endcase
    end
    if (inc0h)
    begin
      t0_high_next = t0_high_reg + 8'h01;
      ovf0h = (t0_high_reg == `BYTE_ONES);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter next values for second timer
  logic [7:0] t1_low_next;
  logic [7:0] t1_high_next;
  logic ovf1;
  always_comb
  begin
    t1_low_next = t1_low_reg;
    t1_high_next = t1_high_reg;
    ovf1 = 1'b0;
    if (inc1)
    begin
      case (cfg1.mode)
        timer_core_pkg::MODE_13BIT:
        begin
          t1_low_next = {t1_low_reg[7:5], t1_low_reg[4:0] + 5'h01};
          if (t1_low_reg[4:0] == `LOW5_ONES)
          begin
            t1_high_next = t1_high_reg + 8'h01;
            ovf1 = (t1_high_reg == `BYTE_ONES);
          end
        end
        timer_core_pkg::MODE_16BIT:
        begin
          t1_low_next = t1_low_reg + 8'h01;
          if (t1_low_reg == `BYTE_ONES)
          begin
            t1_high_next = t1_high_reg + 8'h01;
            ovf1 = (t1_high_reg == `BYTE_ONES);
          end
        end
        timer_core_pkg::MODE_RELOAD:
        begin
          ovf1 = (t1_low_reg == `BYTE_ONES);
          t1_low_next = ovf1 ? t1_high_reg : t1_low_reg + 8'h01;
        end
        default:
        begin
          t1_low_next = t1_low_reg; // Mode 3 holds the second timer
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flag next values: hardware set wins over software clear
  wire x0_set = control_reg[`CTL_X0_TYPE] ? x0_fall : ~x0_level;
  wire x1_set = control_reg[`CTL_X1_TYPE] ? x1_fall : ~x1_level;
  wire t1_flag_set = split0 ? ovf0h : ovf1;

  // Software write and vector clears first, then hardware sets
  logic [7:0] ctl_base;
  logic [7:0] control_next;
  always_comb
  begin
    ctl_base = wr_ctl ? req.wdata : control_reg;
    if (ack_t0_i)
      ctl_base[`CTL_T0_OVF] = 1'b0;
    if (ack_t1_i)
      ctl_base[`CTL_T1_OVF] = 1'b0;
    if (ack_x0_i && control_reg[`CTL_X0_TYPE])
      ctl_base[`CTL_X0_FLAG] = 1'b0;
    if (ack_x1_i && control_reg[`CTL_X1_TYPE])
      ctl_base[`CTL_X1_FLAG] = 1'b0;
    control_next = ctl_base;
    control_next[`CTL_T0_OVF] = ctl_base[`CTL_T0_OVF] | ovf0;
    control_next[`CTL_T1_OVF] = ctl_base[`CTL_T1_OVF] | t1_flag_set;
    control_next[`CTL_X0_FLAG] = ctl_base[`CTL_X0_FLAG] | x0_set;
    control_next[`CTL_X1_FLAG] = ctl_base[`CTL_X1_FLAG] | x1_set;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux
  logic [7:0] rd_mux;
  always_comb
  begin
    case (sfr_addr_i)
      `ADDR_CONTROL: rd_mux = control_reg;
      `ADDR_MODE: rd_mux = mode_reg;
      `ADDR_T0_LOW: rd_mux = t0_low_reg;
      `ADDR_T1_LOW: rd_mux = t1_low_reg;
      `ADDR_T0_HIGH: rd_mux = t0_high_reg;
      `ADDR_T1_HIGH: rd_mux = t1_high_reg;
      `ADDR_PRESCALE: rd_mux = prescale_reg & `CK_WRITE_MASK;
      default: rd_mux = `REG_RESET;
    endcase
  end

  // Address range decode for this block
  assign sfr_hit_o = (sfr_addr_i >= `ADDR_CONTROL) && (sfr_addr_i <= `ADDR_PRESCALE);

  ////////////////////////////////////////////////////////////////////////////
  // Control, mode and prescale registers
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      control_reg <= `REG_RESET;
      mode_reg <= `REG_RESET;
      prescale_reg <= `REG_RESET;
    end
    else
    begin
      control_reg <= control_next;
      mode_reg <= wr_mod ? req.wdata : mode_reg;
      prescale_reg <= wr_ck ? (req.wdata & `CK_WRITE_MASK) : prescale_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Count bytes: software write takes precedence over counting
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      t0_low_reg <= `REG_RESET;
      t0_high_reg <= `REG_RESET;
      t1_low_reg <= `REG_RESET;
      t1_high_reg <= `REG_RESET;
    end
    else
    begin
      t0_low_reg <= wr_t0l ? req.wdata : t0_low_next;
      t0_high_reg <= wr_t0h ? req.wdata : t0_high_next;
      t1_low_reg <= wr_t1l ? req.wdata : t1_low_next;
      t1_high_reg <= wr_t1h ? req.wdata : t1_high_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data and overflow strobe
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rdata_reg <= `REG_RESET;
      strobe_reg <= 1'b0;
    end
    else
    begin
      rdata_reg <= sfr_rd_i ? rd_mux : rdata_reg;
      strobe_reg <= ovf1;
    end
  end

  // Outputs straight from registers
  assign sfr_rdata_o = rdata_reg;
  assign first_timer_irq_o = control_reg[`CTL_T0_OVF];
  assign second_timer_irq_o = control_reg[`CTL_T1_OVF];
  assign ext_irq_line0_o = control_reg[`CTL_X0_FLAG];
  assign ext_irq_line1_o = control_reg[`CTL_X1_FLAG];
  assign second_timer_ovf_strobe_o = strobe_reg;
endmodule

/* File: design/timer_core_cfg.svh */
// Register offsets, field positions, reset values and timing counts for the dual timer core
`ifndef TIMER_CORE_CFG_SVH
`define TIMER_CORE_CFG_SVH
`define ADDR_CONTROL 8'h88
`define ADDR_MODE 8'h89
`define ADDR_T0_LOW 8'h8a
`define ADDR_T1_LOW 8'h8b
`define ADDR_T0_HIGH 8'h8c
`define ADDR_T1_HIGH 8'h8d
`define ADDR_PRESCALE 8'h8e
`define REG_RESET 8'h00
`define CTL_T1_OVF 7
`define CTL_T1_RUN 6
`define CTL_T0_OVF 5
`define CTL_T0_RUN 4
`define CTL_X1_FLAG 3
`define CTL_X1_TYPE 2
`define CTL_X0_FLAG 1
`define CTL_X0_TYPE 0
`define MOD_T1_GATE 7
`define MOD_T1_CNT 6
`define MOD_T1_MODE_HI 5
`define MOD_T1_MODE_LO 4
`define MOD_T0_GATE 3
`define MOD_T0_CNT 2
`define MOD_T0_MODE_HI 1
`define MOD_T0_MODE_LO 0
`define CK_T1_SEL 4
`define CK_T0_SEL 3
`define CK_WRITE_MASK 8'h1b
`define DIV_BY_12 6'h0b
`define DIV_BY_4 6'h03
`define DIV_BY_48 6'h2f
`define DIV_EXT_8 3'h7
`define LOW5_MASK 8'he0
`define BYTE_ONES 8'hff
`define LOW5_ONES 5'h1f
`endif

/* File: design/timer_core_pkg.sv */
// Types shared by the dual timer core
package timer_core_pkg;
  typedef enum logic [1:0] {
    MODE_13BIT = 2'b00,
    MODE_16BIT = 2'b01,
    MODE_RELOAD = 2'b10,
    MODE_SPLIT = 2'b11
  } timer_mode_type;
  typedef struct packed {
    logic pin_gating;
    logic counter_select;
    timer_mode_type mode;
  } timer_cfg_type;
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_type;
endpackage

/* File: design/pin_sync.sv */
// Three-stage pin synchroniser with agreement filter and falling-edge strobe
`timescale 1ns/1ps
module pin_sync (
  input wire logic ref_clk_i, // System clock
  input wire logic rstn_i, // Asynchronous reset, active low
  input wire logic pin_i, // Asynchronous pin
  output logic level_o, // Filtered level
  output logic fall_o // One-cycle falling-edge strobe
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic level_reg;
  wire agree = (s2_reg == s3_reg);
  wire level_next = agree ? s3_reg : level_reg;
  // Synchroniser chain; reset high so an idle pin shows no edge
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      s1_reg <= 1'b1;
      s2_reg <= 1'b1;
      s3_reg <= 1'b1;
      level_reg <= 1'b1;
    end
    else
    begin
      s1_reg <= pin_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      level_reg <= level_next;
    end
  end
  assign level_o = level_reg;
  assign fall_o = level_reg & ~level_next;
endmodule

/* File: design/prescaler.sv */
// Shared prescaler: divides system clock by 12, 4, 48, or external clock by 8
`timescale 1ns/1ps
`include "timer_core_cfg.svh"
module prescaler (
  input wire logic ref_clk_i, // System clock
  input wire logic rstn_i, // Asynchronous reset, active low
  input wire logic [1:0] scale_i, // Prescale field
  input wire logic ext_fall_i, // Synchronised external clock fall
  output logic tick_o // Prescaled one-cycle tick
);
  logic [5:0] div_reg;
  logic [2:0] ext_reg;
  logic tick_reg;
  wire [5:0] limit = (scale_i == 2'b00) ? `DIV_BY_12 : (scale_i == 2'b01) ? `DIV_BY_4 : `DIV_BY_48;
  wire use_ext = (scale_i == 2'b11);
  wire sys_wrap = (div_reg >= limit);
  wire ext_wrap = ext_fall_i && (ext_reg == `DIV_EXT_8);
  // Divider counters and registered tick
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      div_reg <= 6'h00;
      ext_reg <= 3'h0;
      tick_reg <= 1'b0;
    end
    else
    begin
      div_reg <= sys_wrap ? 6'h00 : div_reg + 6'h01;
      ext_reg <= ext_fall_i ? ext_reg + 3'h1 : ext_reg;
      tick_reg <= use_ext ? ext_wrap : sys_wrap;
    end
  end
  assign tick_o = tick_reg;
endmodule

/* File: tb/dual_timer_split_mode_core_sva.sv */
// Port-level checker for the dual timer core
`timescale 1ns/1ps
`include "timer_core_cfg.svh"
module dual_timer_split_mode_core_sva (
  input wire logic ref_clk_i, // System clock
  input wire logic rstn_i, // Reset, active low
  input wire logic sfr_wr_i, // Write strobe
  input wire logic sfr_rd_i, // Read strobe
  input wire logic [7:0] sfr_addr_i, // Register address
  input wire logic [7:0] sfr_wdata_i, // Write data
  input wire logic [7:0] sfr_rdata_o, // Read data
  input wire logic sfr_hit_o, // Address decode
  input wire logic first_timer_irq_o, // First overflow flag
  input wire logic second_timer_irq_o, // Second overflow flag
  input wire logic ext_irq_line0_o, // Line 0 flag
  input wire logic ext_irq_line1_o // Line 1 flag
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  ////////////////////////////////////////////////////////////////////////////
  // Decode and read path
  property p_hit; sfr_hit_o == (sfr_addr_i >= 8'h88 && sfr_addr_i <= 8'h8e); endproperty
  a_hit: assert property (p_hit) else $error("address decode wrong");
  property p_unmapped; sfr_rd_i && !sfr_hit_o |=> sfr_rdata_o == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_rd_hold; !sfr_rd_i |=> $stable(sfr_rdata_o); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved without read");
  property p_ck_unused; sfr_rd_i && sfr_addr_i == `ADDR_PRESCALE |=> (sfr_rdata_o & 8'he4) == 8'h00; endproperty
  a_ck_unused: assert property (p_ck_unused) else $error("unused prescale bits not zero");
  ////////////////////////////////////////////////////////////////////////////
  // Flags set by a control write, and outputs after reset
  property p_set_t1; sfr_wr_i && sfr_addr_i == `ADDR_CONTROL && sfr_wdata_i[7] |=> second_timer_irq_o; endproperty
  a_set_t1: assert property (p_set_t1) else $error("second flag not written");
  property p_set_t0; sfr_wr_i && sfr_addr_i == `ADDR_CONTROL && sfr_wdata_i[5] |=> first_timer_irq_o; endproperty
  a_set_t0: assert property (p_set_t0) else $error("first flag not written");
  property p_set_x1; sfr_wr_i && sfr_addr_i == `ADDR_CONTROL && sfr_wdata_i[3] |=> ext_irq_line1_o; endproperty
  a_set_x1: assert property (p_set_x1) else $error("line 1 flag not written");
  property p_set_x0; sfr_wr_i && sfr_addr_i == `ADDR_CONTROL && sfr_wdata_i[1] |=> ext_irq_line0_o; endproperty
  a_set_x0: assert property (p_set_x0) else $error("line 0 flag not written");
  property p_rst;
    $rose(rstn_i) |-> !first_timer_irq_o && !second_timer_irq_o && !ext_irq_line0_o && sfr_rdata_o == 8'h00;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not clear after reset");
endmodule
bind dual_timer_split_mode_core dual_timer_split_mode_core_sva chk (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
  .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_addr_i(sfr_addr_i), .sfr_wdata_i(sfr_wdata_i),
  .sfr_rdata_o(sfr_rdata_o), .sfr_hit_o(sfr_hit_o), .first_timer_irq_o(first_timer_irq_o),
  .second_timer_irq_o(second_timer_irq_o), .ext_irq_line0_o(ext_irq_line0_o), .ext_irq_line1_o(ext_irq_line1_o));

/* File: tb/dual_timer_split_mode_core_tb_top.sv */
// Self-checking testbench for the dual timer core
`timescale 1ns/1ps
`include "timer_core_cfg.svh"
module dual_timer_split_mode_core_tb_top;
  logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, ext_clk = 1'b1;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic hit, t0_irq, t1_irq, x0_irq, x1_irq, strobe;
  logic ack0 = 1'b0, ack1 = 1'b0, ackx0 = 1'b0, ackx1 = 1'b0;
  logic irq_pin0_n = 1'b1, irq_pin1_n = 1'b1, cnt0 = 1'b1, cnt1 = 1'b1;
  int n_mismatch = 0, total_checks = 0;
  // Strobe spacing per prescale code; external: 8 falls, one every 4 cycles
  int exp_gap [4] = '{12, 4, 48, 32};
  ////////////////////////////////////////////////////////////////////////////
  // Clocks and device
  always #20 clk = ~clk;
  // External clock, each level held two system clocks for the pin filter
  always
  begin
    repeat (2) @(posedge clk);
    #1 ext_clk = ~ext_clk;
  end
  dual_timer_split_mode_core uut (.ref_clk_i(clk), .rstn_i(rstn), .sfr_wr_i(wr), .sfr_rd_i(rd),
    .sfr_addr_i(addr), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata), .sfr_hit_o(hit), .ack_t0_i(ack0),
    .ack_t1_i(ack1), .ack_x0_i(ackx0), .ack_x1_i(ackx1), .ext_irq_pin_line0_i(irq_pin0_n),
    .ext_irq_pin_line1_i(irq_pin1_n), .first_count_input_pin_i(cnt0), .second_count_input_pin_i(cnt1),
    .ext_clk_i(ext_clk), .first_timer_irq_o(t0_irq), .second_timer_irq_o(t1_irq), .ext_irq_line0_o(x0_irq),
    .ext_irq_line1_o(x1_irq), .second_timer_ovf_strobe_o(strobe));
  ////////////////////////////////////////////////////////////////////////////
  // Bus tasks and comparison
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    cyc(1);
    wr = 1'b0;
    cyc(1);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    addr = a;
    rd = 1'b1;
    cyc(1);
    rd = 1'b0;
    chk(rdata, exp);
    cyc(1);
  endtask
  function automatic logic flag(input int k);
    case (k)
      0: return t0_irq;
      1: return t1_irq;
      2: return x0_irq;
      default: return x1_irq;
    endcase
  endfunction
  // Bounded wait for one flag output, then check it is set
  task automatic wait_flag(input int k, input int lim);
    int n;
    n = 0;
    while (flag(k) !== 1'b1 && n < lim)
    begin
      cyc(1);
      n++;
    end
    chk({7'h00, flag(k)}, 8'h01);
  endtask
  // Measure the spacing of overflow strobes, second gap compared
  task automatic strobe_gap(input int exp);
    int n;
    n = 0;
    while (strobe !== 1'b1 && n < 400)
    begin
      cyc(1);
      n++;
    end
    repeat (2)
    begin
      n = 1;
      cyc(1);
      while (strobe !== 1'b1 && n < 400)
      begin
        cyc(1);
        n++;
      end
    end
    chk(8'(n), 8'(exp));
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Watchdog
  initial
  begin
    #(40 * 10000);
    n_mismatch++;
    final_report();
  end
  ////////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial
  begin
    int n;
    repeat (4) @(posedge clk);
    #1 rstn = 1'b1;
    cyc(1);
    for (int a = 8'h87; a <= 8'h8f; a++)
    begin
      rd_chk(8'(a), 8'h00);
      chk({7'h00, hit}, {7'h00, (a >= `ADDR_CONTROL && a <= `ADDR_PRESCALE)});
    end
    wr_reg(`ADDR_PRESCALE, 8'hff);
    rd_chk(`ADDR_PRESCALE, 8'h1b);
    wr_reg(`ADDR_CONTROL, 8'haa);
    chk({4'h0, t1_irq, t0_irq, x1_irq, x0_irq}, 8'h0f);
    rd_chk(`ADDR_CONTROL, 8'haa);
    wr_reg(`ADDR_CONTROL, 8'h00);
    for (int a = 8'h8a; a <= 8'h8d; a++)
    begin
      wr_reg(8'(a), 8'(a) ^ 8'h5a);
      rd_chk(8'(a), 8'(a) ^ 8'h5a);
    end
    $display("test registers done");
    wr_reg(`ADDR_PRESCALE, 8'h08);
    wr_reg(`ADDR_MODE, 8'h01);
    wr_reg(`ADDR_T0_LOW, 8'hfd);
    wr_reg(`ADDR_T0_HIGH, 8'hff);
    wr_reg(`ADDR_CONTROL, 8'h10);
    wait_flag(0, 10);
    wr_reg(`ADDR_CONTROL, 8'h20);
    rd_chk(`ADDR_T0_HIGH, 8'h00);
    rd_chk(`ADDR_CONTROL, 8'h20);
    ack0 = 1'b1;
    cyc(1);
    ack0 = 1'b0;
    cyc(1);
    chk({7'h00, t0_irq}, 8'h00);
    wr_reg(`ADDR_MODE, 8'h00);
    wr_reg(`ADDR_T0_LOW, 8'h1e);
    wr_reg(`ADDR_T0_HIGH, 8'hff);
    wr_reg(`ADDR_CONTROL, 8'h10);
    wait_flag(0, 10);
    wr_reg(`ADDR_CONTROL, 8'h00);
    rd_chk(`ADDR_T0_HIGH, 8'h00);
    wr_reg(`ADDR_PRESCALE, 8'h01);
    wr_reg(`ADDR_MODE, 8'h02);
    wr_reg(`ADDR_T0_HIGH, 8'h80);
    wr_reg(`ADDR_T0_LOW, 8'hfe);
    wr_reg(`ADDR_CONTROL, 8'h10);
    wait_flag(0, 20);
    wr_reg(`ADDR_CONTROL, 8'h00);
    rd_chk(`ADDR_T0_LOW, 8'h80);
    rd_chk(`ADDR_T0_HIGH, 8'h80);
    $display("test count modes done");
    wr_reg(`ADDR_MODE, 8'h20);
    wr_reg(`ADDR_T1_HIGH, 8'hff);
    wr_reg(`ADDR_T1_LOW, 8'hff);
    wr_reg(`ADDR_CONTROL, 8'h40);
    for (int k = 0; k < 4; k++)
    begin
      wr_reg(`ADDR_PRESCALE, 8'(k));
      strobe_gap(exp_gap[k]);
    end
    chk({7'h00, t1_irq}, 8'h01);
    $display("test prescale done");
    wr_reg(`ADDR_CONTROL, 8'h00);
    wr_reg(`ADDR_PRESCALE, 8'h08);
    wr_reg(`ADDR_MODE, 8'h27);
    wr_reg(`ADDR_T0_HIGH, 8'hfe);
    wr_reg(`ADDR_T0_LOW, 8'hfd);
    wr_reg(`ADDR_CONTROL, 8'h40);
    wait_flag(1, 10);
    ack1 = 1'b1;
    cyc(1);
    ack1 = 1'b0;
    chk({7'h00, t1_irq}, 8'h00);
    wr_reg(`ADDR_CONTROL, 8'h00);
    strobe_gap(12);
    chk({7'h00, t1_irq}, 8'h00);
    wr_reg(`ADDR_CONTROL, 8'h10);
    repeat (3)
    begin
      cnt0 = 1'b0;
      cyc(3);
      cnt0 = 1'b1;
      cyc(3);
    end
    wait_flag(0, 10);
    wr_reg(`ADDR_CONTROL, 8'h00);
    rd_chk(`ADDR_T0_LOW, 8'h00);
    wr_reg(`ADDR_MODE, 8'h37);
    cyc(2);
    n = 0;
    repeat (120)
    begin
      cyc(1);
      if (strobe === 1'b1) n++;
    end
    chk(8'(n), 8'h00);
    $display("test split done");
    wr_reg(`ADDR_MODE, 8'h09);
    wr_reg(`ADDR_T0_LOW, 8'hf0);
    wr_reg(`ADDR_T0_HIGH, 8'hff);
    irq_pin0_n = 1'b0;
    cyc(6);
    wr_reg(`ADDR_CONTROL, 8'h10);
    cyc(20);
    rd_chk(`ADDR_T0_LOW, 8'hf0);
    chk({7'h00, x0_irq}, 8'h01);
    ackx0 = 1'b1;
    cyc(1);
    ackx0 = 1'b0;
    cyc(1);
    chk({7'h00, x0_irq}, 8'h01);
    irq_pin0_n = 1'b1;
    wait_flag(0, 40);
    wr_reg(`ADDR_CONTROL, 8'h04);
    irq_pin1_n = 1'b0;
    wait_flag(3, 10);
    ackx1 = 1'b1;
    cyc(1);
    ackx1 = 1'b0;
    cyc(3);
    chk({7'h00, x1_irq}, 8'h00);
    irq_pin1_n = 1'b1;
    $display("test gate and lines done");
    wr_reg(`ADDR_MODE, 8'h50);
    wr_reg(`ADDR_T1_LOW, 8'hfe);
    wr_reg(`ADDR_T1_HIGH, 8'hff);
    wr_reg(`ADDR_CONTROL, 8'h40);
    repeat (2)
    begin
      cnt1 = 1'b0;
      cyc(3);
      cnt1 = 1'b1;
      cyc(3);
    end
    wait_flag(1, 10);
    wr_reg(`ADDR_CONTROL, 8'h00);
    rd_chk(`ADDR_T1_LOW, 8'h00);
    rd_chk(`ADDR_T1_HIGH, 8'h00);
    $display("test second counter done");
    final_report();
  end
endmodule
